// *** hw/ddr3_init_ctrl.sv ***
// controller that powers up, resets and programs a ddr3 sdram, steered over apb
//
// Overview of operation
// RULE1: device moves one 8n-bit core word per access, two n-bit pin beats per clock.
// RULE2: device bursts eight beats, or four when chopped, from the chosen column.
// RULE3: activate opens bank and row before any read or write to that bank.
// RULE4: read/write address gives column; A10 auto precharge; A12 chop when on-the-fly.
// RULE5: cold reset held low at least 200 us.
// RULE6: clock enable low at least 10 ns before reset release.
// RULE7: wait 500 us after reset release before raising clock enable.
// RULE8: memory clock runs stable at least 10 ns or 5 clocks before clock enable.
// RULE9: a nop is registered before clock enable rises.
// RULE10: clock enable stays high until lock and calibration waits expire.
// RULE11: device keeps termination off during reset and until clock enable high.
// RULE12: termination input static from clock enable high; low if nominal rtt used.
// RULE13: wait reset-exit time, max of tXS and 5 clocks, before first load.
// RULE14: load MR2, MR3, MR1, MR0 in that order, then long zq calibration.
// RULE15: bank bits pick the mode register being loaded.
// RULE16: MR1 loaded with dll enabled, MR0 loaded with dll reset.
// RULE17: only nop or deselect between last load and long zq calibration.
// RULE18: ready only after dll lock and zq initial calibration both elapse.
// RULE19: warm reset held at least 100 ns, then the same sequence repeats.
// RULE20: every mode register is written in full after each reset.
// RULE21: each load drives every field of the target register.
// RULE22: device keeps array contents across loads and dll reset.
// RULE23: consecutive loads are spaced by at least tMRD.
// RULE24: after a load only load, nop or deselect until tMOD elapses.
// RULE25: loads in normal operation only while all banks are precharged.
// RULE26: sequence runs as a state machine with counters derived from the clock period.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
module ddr3_init_ctrl
  import ddr3_init_pkg::*;
#(
  parameter int RST_COLD_CYCLES = RST_COLD_CYC,
  parameter int CKE_WAIT_CYCLES = CKE_WAIT_CYC,
  parameter int CNT_W           = 17
)(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire apb_req_type apb_req,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output ddr_cmd_type      ddr_cmd,
  output logic             ddr_reset_n,
  output logic             ddr_cke,
  output logic             ddr_ck,
  output logic             ddr_odt
);

  // ------------------------
  // elaboration checks
  // ------------------------
  if (CNT_W > 30 || RST_COLD_CYCLES >= (1 << CNT_W) || CKE_WAIT_CYCLES >= (1 << CNT_W)
      || CAL_CYC >= (1 << CNT_W) || RST_COLD_CYCLES < RST_WARM_CYC)
    $error("wait counts do not fit the counter width");

  typedef enum logic [3:0] {
    S_IDLE, S_RST, S_CKE_LOW, S_XPR, S_MRS, S_MOD, S_CAL, S_READY
  } state_type;

  state_type        state;
  logic [CNT_W-1:0] cnt;
  logic [1:0]       mrs_idx;
  logic [13:0]      mr [4];
  logic             go;
  logic             warm;
  logic             odt_level;
  logic             req_tog;
  logic             ack_tog;
  logic             refuse_evt;
  logic             refused;
  logic [22:0]      cmd_word;
  logic [7:0]       bank_open;
  logic             ready;
  logic             issued;
  logic             slot;
  logic             setup;
  logic [7:0]       ofs;
  logic             pend;

  assign slot  = ddr_ck;   // command changes as ck falls, sampled at next rise
  assign setup = apb_req.psel && !apb_req.penable;
  assign ofs   = apb_req.paddr[7:0];
  assign pend  = req_tog != ack_tog;

  // ------------------------
  // apb slave: zero wait states, read data captured in setup
  // ------------------------
  function automatic logic mapped(input logic [7:0] a);
    return a <= OFS_CMD && a[1:0] == 2'h0;
  endfunction : mapped

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        pslverr <= !mapped(ofs);
        prdata  <= 32'h00000000;
        unique case (ofs)
          OFS_CTRL:   prdata <= {29'h0, odt_level, warm, 1'b0};
          OFS_STATUS: prdata <= {20'h0, 4'(state), 4'h0, refused, pend || refuse_evt,
                                 !ready && state != S_IDLE, ready};
          OFS_MR0:    prdata <= {18'h0, mr[0]};
          OFS_MR1:    prdata <= {18'h0, mr[1]};
          OFS_MR2:    prdata <= {18'h0, mr[2]};
          OFS_MR3:    prdata <= {18'h0, mr[3]};
          OFS_CMD:    prdata <= {9'h0, cmd_word};
          default:    prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      go        <= 1'b0;
      warm      <= 1'b0;
      odt_level <= 1'b0;
      req_tog   <= 1'b0;
      refused   <= 1'b0;
      cmd_word  <= 23'h000000;
      for (int i = 0; i < 4; i++)
        mr[i] <= MR_RESET;
    end
    else
    begin
      go <= 1'b0;
      // a refusal in the clearing cycle still sets the flag
      if (refuse_evt)
        refused <= 1'b1;
      if (apb_req.psel && apb_req.penable && apb_req.pwrite)
      begin
        unique case (ofs)
          OFS_CTRL:
          begin
            go        <= apb_req.pwdata[CTRL_GO];
            warm      <= apb_req.pwdata[CTRL_WARM];
            odt_level <= apb_req.pwdata[CTRL_ODT];
          end
          OFS_STATUS:
            if (apb_req.pwdata[ST_REFUSED] && !refuse_evt)
              refused <= 1'b0;
          OFS_MR0: mr[0] <= apb_req.pwdata[13:0];
          OFS_MR1: mr[1] <= apb_req.pwdata[13:0];
          OFS_MR2: mr[2] <= apb_req.pwdata[13:0];
          OFS_MR3: mr[3] <= apb_req.pwdata[13:0];
          OFS_CMD:
            if (!pend)
            begin
              cmd_word <= apb_req.pwdata[22:0];
              req_tog  <= !req_tog;
            end
          default: ;
        endcase
      end
    end
  end

  // ------------------------
  // memory clock: free running so it is stable long before cke
  // ------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ddr_ck <= 1'b0;
    else
      ddr_ck <= !ddr_ck; // RULE8
  end

  // ------------------------
  // load order and forced fields
  // ------------------------
  function automatic logic [2:0] seq_ba(input logic [1:0] i);
    logic [2:0] r;
    r = BA_MR0;
    unique case (i)
      2'h0: r = BA_MR2; // RULE14 RULE15
      2'h1: r = BA_MR3;
      2'h2: r = BA_MR1;
      2'h3: r = BA_MR0;
    endcase
    return r;
  endfunction : seq_ba

  function automatic logic [13:0] seq_val(input logic [2:0] ba, input logic init);
    logic [13:0] v;
    v = mr[ba[1:0]];
    if (init && ba == BA_MR1)
      v[MR1_DLL_DIS] = 1'b0; // RULE16
    if (init && ba == BA_MR0)
      v[MR0_DLL_RST] = 1'b1; // RULE16
    return v;
  endfunction : seq_val

  // ------------------------
  // sequencer
  // ------------------------
  logic [2:0]  u_op;
  logic [2:0]  u_ba;
  logic [13:0] u_addr;
  logic        u_ok;
  assign u_op   = cmd_word[CMD_OP_LSB +: 3];
  assign u_ba   = cmd_word[CMD_BA_LSB +: 3];
  assign u_addr = cmd_word[13:0];

  always_comb
  begin
    unique case (u_op)
      OP_ACT:  u_ok = !bank_open[u_ba];                   // RULE3
      OP_RD,
      OP_WR:   u_ok = bank_open[u_ba];                    // RULE3
      OP_PRE:  u_ok = 1'b1;
      OP_MRS:  u_ok = bank_open == 8'h00 && u_ba[2] == 1'b0; // RULE25
      default: u_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state       <= S_IDLE;
      cnt         <= '0;
      mrs_idx     <= 2'h0;
      ddr_reset_n <= 1'b0;
      ddr_cke     <= 1'b0;
      ddr_odt     <= 1'b0;
      ddr_cmd     <= CMD_DESEL;
      ready       <= 1'b0;
      issued      <= 1'b0;
      ack_tog     <= 1'b0;
      refuse_evt  <= 1'b0;
      bank_open   <= 8'h00;
    end
    else
    begin
      issued     <= 1'b0;
      refuse_evt <= 1'b0;
      if (cnt != '0)
        cnt <= cnt - 1'b1;
      if (slot)
        ddr_cmd <= mk_cmd(RCW_NOP, 3'h0, 14'h0000); // RULE9 RULE17
      if (go)
      begin
        // cke falls with reset, so it is low for the whole hold
        state       <= S_RST;
        ddr_reset_n <= 1'b0;
        ddr_cke     <= 1'b0; // RULE6
        ddr_odt     <= 1'b0;
        ready       <= 1'b0;
        bank_open   <= 8'h00;
        cnt         <= warm ? CNT_W'(RST_WARM_CYC) : CNT_W'(RST_COLD_CYCLES); // RULE5 RULE19
      end
      else
      begin
        unique case (state)
          S_IDLE: ;
          S_RST:
            if (cnt == '0)
            begin
              ddr_reset_n <= 1'b1;
              cnt         <= CNT_W'(CKE_WAIT_CYCLES); // RULE7
              state       <= S_CKE_LOW;
            end
          S_CKE_LOW:
            if (cnt == '0 && slot)
            begin
              ddr_cke <= 1'b1; // RULE26
              // rtt nominal on in MR1 forces a low, static odt
              ddr_odt <= odt_level && mr[1][2] == 1'b0 && mr[1][6] == 1'b0
                         && mr[1][9] == 1'b0; // RULE12
              cnt     <= CNT_W'(TXPR_CYC); // RULE13
              mrs_idx <= 2'h0;
              state   <= S_XPR;
            end
          S_XPR,
          S_MRS:
            if (cnt == '0 && slot)
            begin
              // all four loads every time, each with the full value
              ddr_cmd <= mk_cmd(RCW_MRS, seq_ba(mrs_idx),
                                seq_val(seq_ba(mrs_idx), 1'b1)); // RULE20 RULE21
              issued  <= 1'b1;
              mrs_idx <= mrs_idx + 2'h1;
              cnt     <= (mrs_idx == 2'h3) ? CNT_W'(TMOD_CYC) : CNT_W'(TMRD_CYC); // RULE23
              state   <= (mrs_idx == 2'h3) ? S_MOD : S_MRS;
            end
          S_MOD:
            if (cnt == '0 && slot)
            begin
              ddr_cmd <= mk_cmd(RCW_ZQ, 3'h0, 14'h0400); // RULE14 RULE24
              issued  <= 1'b1;
              cnt     <= CNT_W'(CAL_CYC);
              state   <= S_CAL;
            end
          S_CAL:
            if (cnt == '0)
            begin
              ready <= 1'b1; // RULE18
              state <= S_READY;
            end
          S_READY:
            if (pend && cnt == '0 && slot)
            begin
              ack_tog <= !ack_tog;
              cnt     <= CNT_W'(TCK_CYC);
              if (!u_ok)
                refuse_evt <= 1'b1;
              else
              begin
                issued <= 1'b1;
                unique case (u_op)
                  OP_ACT:
                  begin
                    ddr_cmd <= mk_cmd(RCW_ACT, u_ba, u_addr); // RULE3
                    bank_open[u_ba] <= 1'b1;
                  end
                  OP_RD,
                  OP_WR:
                  begin
                    // A12 only matters with on-the-fly burst length
                    ddr_cmd <= mk_cmd(u_op == OP_RD ? RCW_RD : RCW_WR, u_ba,
                                      {u_addr[13], u_addr[BC_BIT] ||
                                       mr[0][1:0] != BL_OTF, u_addr[11:0]}); // RULE4
                    if (u_addr[AP_BIT])
                      bank_open[u_ba] <= 1'b0; // RULE4
                  end
                  OP_PRE:
                  begin
                    ddr_cmd <= mk_cmd(RCW_PRE, u_ba, u_addr);
                    if (u_addr[AP_BIT])
                      bank_open <= 8'h00;
                    else
                      bank_open[u_ba] <= 1'b0;
                  end
                  default:
                  begin
                    ddr_cmd <= mk_cmd(RCW_MRS, u_ba, u_addr);
                    cnt     <= CNT_W'(TMOD_CYC); // RULE24
                  end
                endcase
              end
            end
        endcase
      end
    end
  end

  // ------------------------
  // checks
  // ------------------------
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] since_rel;
  logic [CNT_W-1:0] since_cke_low;
  logic [CNT_W-1:0] since_mrs;
  logic [CNT_W-1:0] since_zq;
  logic             is_mrs;
  logic             init_run;
  assign is_mrs   = issued && ddr_cmd.ras_n == 1'b0 && ddr_cmd.cas_n == 1'b0;
  assign init_run = state == S_MRS || state == S_MOD || state == S_CAL;

  function automatic logic [CNT_W-1:0] sat(input logic [CNT_W-1:0] c, input logic clr);
    return clr ? '0 : (&c ? c : c + 1'b1);
  endfunction : sat

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      low_cnt       <= '0;
      since_rel     <= '0;
      since_cke_low <= '0;
      since_mrs     <= '1;
      since_zq      <= '0;
    end
    else
    begin
      low_cnt       <= sat(low_cnt, ddr_reset_n);
      since_rel     <= sat(since_rel, !ddr_reset_n);
      since_cke_low <= sat(since_cke_low, ddr_cke);
      since_mrs     <= sat(since_mrs, is_mrs);
      since_zq      <= sat(since_zq, issued && state == S_CAL);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_reset_hold_time: assert property ($rose(ddr_reset_n) |-> low_cnt >= RST_WARM_CYC) // RULE5
    else $error("reset released too early");
  chk_cke_low_lead: assert property ($rose(ddr_reset_n) |-> since_cke_low >= CKE_LOW_CYC) // RULE6
    else $error("cke not low long enough before reset release");
  chk_cke_rise_wait: assert property ($rose(ddr_cke) |-> since_rel > CKE_WAIT_CYCLES) // RULE7
    else $error("cke raised before the post reset wait");
  chk_cke_held_high: assert property (init_run |-> ddr_cke && ddr_reset_n) // RULE10
    else $error("cke dropped during initialisation");
  chk_odt_static: assert property (init_run && $past(init_run) |-> $stable(ddr_odt)) // RULE12
    else $error("odt moved during initialisation");
  chk_load_order: assert property ($rose(state == S_MOD) // RULE14 RULE16
    |-> ddr_cmd.ba == BA_MR0 && ddr_cmd.addr[MR0_DLL_RST])
    else $error("last initial load is not MR0 with dll reset");
  chk_dll_enable: assert property (is_mrs && init_run && ddr_cmd.ba == BA_MR1 // RULE16
    |-> !ddr_cmd.addr[MR1_DLL_DIS])
    else $error("MR1 loaded with dll disabled");
  chk_mrs_spacing: assert property (is_mrs |-> $past(since_mrs) >= TMRD_CYC - 1) // RULE23
    else $error("loads spaced below tMRD");
  chk_zq_after_mod: assert property (issued && state == S_CAL // RULE17 RULE24
    |-> $past(since_mrs) >= TMOD_CYC - 1)
    else $error("zq calibration before tMOD");
  chk_ready_wait: assert property ($rose(ready) |-> since_zq >= CAL_CYC) // RULE18
    else $error("ready before lock and calibration waits");

endmodule : ddr3_init_ctrl

// *** hw/ddr3_init_pkg.sv ***
// constants, types and helpers shared by the ddr3 power-up controller
package ddr3_init_pkg;

  // ------------------------
  // clocking and timing
  // ------------------------
  localparam int CLK_PS      = 5000;   // core_clk period
  localparam int TCK_CYC     = 2;      // core cycles per memory clock
  localparam int RST_COLD_US = 200;
  localparam int RST_WARM_NS = 100;
  localparam int CKE_LOW_NS  = 10;
  localparam int CKE_WAIT_US = 500;
  localparam int TXS_NS      = 170;
  localparam int TXPR_TCK    = 5;
  localparam int TMRD_TCK    = 4;
  localparam int TMOD_TCK    = 12;
  localparam int TDLLK_TCK   = 512;
  localparam int TZQINIT_TCK = 512;

  function automatic int cyc_ps(input int ps);
    return (ps + CLK_PS - 1) / CLK_PS;
  endfunction : cyc_ps

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : imax

  localparam int RST_COLD_CYC = cyc_ps(RST_COLD_US * 1000000);
  localparam int RST_WARM_CYC = cyc_ps(RST_WARM_NS * 1000);
  localparam int CKE_LOW_CYC  = cyc_ps(CKE_LOW_NS * 1000);
  localparam int CKE_WAIT_CYC = cyc_ps(CKE_WAIT_US * 1000000);
  localparam int TXPR_CYC     = imax(cyc_ps(TXS_NS * 1000), TXPR_TCK * TCK_CYC);
  localparam int TMRD_CYC     = TMRD_TCK * TCK_CYC;
  localparam int TMOD_CYC     = TMOD_TCK * TCK_CYC;
  localparam int CAL_CYC      = imax(TDLLK_TCK, TZQINIT_TCK) * TCK_CYC;

  // ------------------------
  // register map and fields
  // ------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MR0    = 8'h08;
  localparam logic [7:0] OFS_MR1    = 8'h0C;
  localparam logic [7:0] OFS_MR2    = 8'h10;
  localparam logic [7:0] OFS_MR3    = 8'h14;
  localparam logic [7:0] OFS_CMD    = 8'h18;
  localparam int CTRL_GO      = 0;
  localparam int CTRL_WARM    = 1;
  localparam int CTRL_ODT     = 2;
  localparam int ST_READY     = 0;
  localparam int ST_BUSY      = 1;
  localparam int ST_PEND      = 2;
  localparam int ST_REFUSED   = 3;
  localparam int ST_STATE_LSB = 8;
  localparam int CMD_BA_LSB   = 16;
  localparam int CMD_OP_LSB   = 20;
  localparam logic [13:0] MR_RESET = 14'h0000;

  // ------------------------
  // command encodings
  // ------------------------
  localparam logic [2:0] OP_ACT = 3'h0;
  localparam logic [2:0] OP_RD  = 3'h1;
  localparam logic [2:0] OP_WR  = 3'h2;
  localparam logic [2:0] OP_PRE = 3'h3;
  localparam logic [2:0] OP_MRS = 3'h4;
  // ras_n, cas_n, we_n
  localparam logic [2:0] RCW_NOP = 3'h7;
  localparam logic [2:0] RCW_MRS = 3'h0;
  localparam logic [2:0] RCW_ACT = 3'h3;
  localparam logic [2:0] RCW_RD  = 3'h5;
  localparam logic [2:0] RCW_WR  = 3'h4;
  localparam logic [2:0] RCW_PRE = 3'h2;
  localparam logic [2:0] RCW_ZQ  = 3'h6;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam int MR0_DLL_RST = 8;
  localparam int MR1_DLL_DIS = 0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [13:0] addr;
  } ddr_cmd_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  localparam ddr_cmd_type CMD_DESEL = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0000};

  function automatic ddr_cmd_type mk_cmd(input logic [2:0] rcw, input logic [2:0] ba,
                                         input logic [13:0] addr);
    return '{1'b0, rcw[2], rcw[1], rcw[0], ba, addr};
  endfunction : mk_cmd

endpackage : ddr3_init_pkg

// *** bench/ddr3_dev_model.sv ***
// behavioural ddr3 device as seen at the controller's pins
module ddr3_dev_model
  import ddr3_init_pkg::*;
(
  input  wire logic        ddr_ck,
  input  wire logic        ddr_reset_n,
  input  wire logic        ddr_cke,
  input  wire ddr_cmd_type ddr_cmd,
  output logic             cmd_seen,
  output ddr_cmd_type      seen_cmd,
  output int               viol_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  bank_open;
  logic [13:0] mr [4];
  logic [3:0]  mr_done;
  logic        cke_q;
  logic        last_nop;
  int          beats;
  logic [2:0]  rcw;
  assign rcw = {ddr_cmd.ras_n, ddr_cmd.cas_n, ddr_cmd.we_n};
  initial viol_cnt = 0;
  // ------------------------
  // commands registered on the memory clock rise
  // ------------------------
  always @(posedge ddr_ck or negedge ddr_reset_n)
  begin
    if (!ddr_reset_n)
    begin
      cke_q     <= 1'b0;
      cmd_seen  <= 1'b0;
      bank_open <= 8'h00;
      mr_done   <= 4'h0;
    end
    else
    begin
      cke_q    <= ddr_cke;
      cmd_seen <= 1'b0;
      last_nop <= ddr_cmd.cs_n || rcw == RCW_NOP;
      if (ddr_cke && !cke_q && !last_nop)
        viol_cnt <= viol_cnt + 1;
      if (ddr_cke && !ddr_cmd.cs_n && rcw != RCW_NOP)
      begin
        cmd_seen <= 1'b1;
        seen_cmd <= ddr_cmd;
        case (rcw)
          RCW_ACT:
          begin
            if (bank_open[ddr_cmd.ba])
              viol_cnt <= viol_cnt + 1;
            bank_open[ddr_cmd.ba] <= 1'b1;
          end
          RCW_RD, RCW_WR:
          begin
            if (!bank_open[ddr_cmd.ba] || mr_done != 4'hF)
              viol_cnt <= viol_cnt + 1;
            if (ddr_cmd.addr[AP_BIT])
              bank_open[ddr_cmd.ba] <= 1'b0;
            // no data pins here, so a burst is only sized, not moved
            beats <= (mr[0][1:0] == 2'h2 || (mr[0][1:0] == BL_OTF
                      && !ddr_cmd.addr[BC_BIT])) ? 4 : 8;
          end
          RCW_PRE:
            bank_open <= ddr_cmd.addr[AP_BIT] ? 8'h00
                         : bank_open & ~(8'h01 << ddr_cmd.ba);
          RCW_MRS:
          begin
            // array state is left alone by a load
            mr[ddr_cmd.ba[1:0]]      <= ddr_cmd.addr;
            mr_done[ddr_cmd.ba[1:0]] <= 1'b1;
          end
          default:
            ;
        endcase
      end
    end
  end
endmodule : ddr3_dev_model

// *** bench/testbench.sv ***
// self-checking bench for the ddr3 power-up controller
module testbench
  import ddr3_init_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int COLD = 40;
  localparam int CKW  = 60;
  logic        core_clk, reset, pready, pslverr, ddr_reset_n, ddr_cke, ddr_ck, ddr_odt;
  logic        cmd_seen, rn_q, ke_q, exp_odt, od;
  apb_req_type req;
  logic [31:0] prdata, st;
  ddr_cmd_type ddr_cmd, seen_cmd, ec;
  int          viol_cnt, error_cnt, num_checks, cyc, t_go, t_rst, t_cke, t_mrs, t_zq;
  int          hold_exp, i, n;
  logic [13:0] mr [4];
  logic [13:0] ad, ex;
  logic [20:0] m;
  logic [33:0] e;
  logic [33:0] rq [$];
  ddr_cmd_type cq [$];
  logic [2:0]  op_t [10] = '{OP_ACT, OP_WR, OP_RD, OP_RD, OP_ACT, OP_MRS, OP_PRE, OP_MRS,
                             3'h5, OP_MRS};
  logic [2:0]  rc_t [10] = '{RCW_ACT, RCW_WR, RCW_RD, RCW_RD, RCW_ACT, RCW_MRS, RCW_PRE,
                             RCW_MRS, RCW_NOP, RCW_MRS};
  logic [2:0]  ba_t [10] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h3, 3'h2, 3'h0, 3'h2, 3'h1, 3'h4};
  logic [9:0]  ap_v = 10'b0001000100;
  logic [9:0]  ok_v = 10'b0011010111;

  ddr3_init_ctrl #(.RST_COLD_CYCLES(COLD), .CKE_WAIT_CYCLES(CKW)) dut (
    .core_clk(core_clk), .reset(reset), .apb_req(req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .ddr_cmd(ddr_cmd), .ddr_reset_n(ddr_reset_n), .ddr_cke(ddr_cke),
    .ddr_ck(ddr_ck), .ddr_odt(ddr_odt));
  ddr3_dev_model mem (.ddr_ck(ddr_ck), .ddr_reset_n(ddr_reset_n), .ddr_cke(ddr_cke),
    .ddr_cmd(ddr_cmd), .cmd_seen(cmd_seen), .seen_cmd(seen_cmd), .viol_cnt(viol_cnt));

  // ------------------------
  // shared tasks
  // ------------------------
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // one idle edge after each transfer so req is never assigned twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    req <= '{1'b1, 1'b0, w, {24'h0, a}, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    if (k >= 20)
    begin
      check(1'b0, "bus hang");
      close_out();
    end
    req <= '0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  // e: care bit, error bit, data; no care bit for polling reads
  task automatic rd(input logic [7:0] a, input logic [33:0] x, output logic [31:0] q);
    rq.push_back(x);
    apb(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic poll(input int bit_no, input logic v, input int lim);
    n = 0;
    do
    begin
      rd(OFS_STATUS, 34'h0, st);
      n++;
    end
    while (st[bit_no] !== v && n < lim);
    if (n >= lim)
    begin
      check(1'b0, "status wait ran out");
      close_out();
    end
  endtask : poll

  function automatic ddr_cmd_type mk(input logic [2:0] r, input logic [2:0] b,
                                     input logic [13:0] a);
    return {1'b0, r, b, a};
  endfunction : mk

  // one full power-up; w picks the short warm hold
  task automatic boot(input logic w);
    t_mrs = 0;
    cq.push_back(mk(RCW_MRS, BA_MR2, mr[2]));
    cq.push_back(mk(RCW_MRS, BA_MR3, mr[3]));
    cq.push_back(mk(RCW_MRS, BA_MR1, mr[1] & 14'h3FFE));
    cq.push_back(mk(RCW_MRS, BA_MR0, mr[0] | 14'h0100));
    cq.push_back(mk(RCW_ZQ, 3'h0, 14'h0400));
    hold_exp = w ? RST_WARM_CYC : COLD;
    wr(OFS_CTRL, {29'h0, od, w, 1'b1});
    t_go = cyc;
    poll(ST_STATE_LSB + 2, 1'b1, 1000);
    poll(ST_READY, 1'b1, 1000);
    check(st[11:8] === 4'h7 && st[1] === 1'b0, "ready state");
    check(cyc - t_zq >= CAL_CYC, "ready before calibration wait");
  endtask : boot

  // ------------------------
  // watchers
  // ------------------------
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (req.psel && req.penable && pready === 1'b1 && !req.pwrite)
    begin
      e = rq.pop_front();
      if (e[33])
        check({pslverr, prdata} === e[32:0], "read data or error");
    end
    if (ddr_reset_n === 1'b1 && rn_q === 1'b0)
    begin
      check(cyc - t_go >= hold_exp, "memory reset too short");
      check(ddr_cke === 1'b0 && ke_q === 1'b0, "cke not low at release");
      check(ddr_odt === 1'b0, "odt on during reset");
      t_rst = cyc;
    end
    if (ddr_cke === 1'b1 && ke_q === 1'b0)
    begin
      check(cyc - t_rst >= CKW, "cke raised early");
      check(ddr_odt === exp_odt, "odt level");
      t_cke = cyc;
    end
    if (ke_q === 1'b1 && ddr_cke !== 1'b1 && ddr_reset_n === 1'b1)
      check(1'b0, "cke dropped");
    rn_q = ddr_reset_n;
    ke_q = ddr_cke;
  end

  always @(posedge ddr_ck)
  begin
    if (cmd_seen === 1'b1)
    begin
      if (cq.size() == 0)
        check(1'b0, "unexpected command");
      else
      begin
        ec = cq.pop_front();
        m = ({ec.ras_n, ec.cas_n, ec.we_n} == RCW_ZQ) ? 21'h1E0400 : 21'h1FFFFF;
        check((seen_cmd & m) === (ec & m), "command pins");
        if ({ec.ras_n, ec.cas_n, ec.we_n} == RCW_MRS)
        begin
          check(t_mrs == 0 ? cyc - t_cke >= TXPR_CYC : cyc - t_mrs >= TMRD_CYC,
                "load spacing");
          t_mrs = cyc;
        end
        if ({ec.ras_n, ec.cas_n, ec.we_n} == RCW_ZQ)
        begin
          check(cyc - t_mrs >= TMOD_CYC, "zq too soon");
          t_zq = cyc;
        end
      end
    end
  end

  // ------------------------
  // clock and main sequence
  // ------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    reset = 1'b1;
    req = '0;
    {error_cnt, num_checks, cyc, t_go, t_rst, t_cke, t_mrs, t_zq, hold_exp} = '0;
    void'($urandom(32'h604D));
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(OFS_STATUS, {2'b10, 32'h0}, st);
    rd(8'h1C, {2'b11, 32'h0}, st);
    rd(8'h02, {2'b11, 32'h0}, st);
    for (i = 0; i < 4; i++)
    begin
      rd(OFS_MR0 + 8'(4 * i), {2'b10, 32'h0}, st);
      mr[i] = 14'($urandom);
      wr(OFS_MR0 + 8'(4 * i), {18'h0, mr[i]});
      rd(OFS_MR0 + 8'(4 * i), {2'b10, 18'h0, mr[i]}, st);
    end
    od = 1'($urandom);
    exp_odt = od & ~(mr[1][2] | mr[1][6] | mr[1][9]);
    wr(OFS_CTRL, {29'h0, od, 2'b11});
    boot(1'b0);
    for (i = 0; i < 10; i++)
    begin
      ad = 14'($urandom) & 14'h2BFF | {3'h0, ap_v[i], 10'h0};
      ex = ad;
      if (rc_t[i] == RCW_RD || rc_t[i] == RCW_WR)
        ex[BC_BIT] = (mr[0][1:0] != BL_OTF);
      if (ok_v[i])
        cq.push_back(mk(rc_t[i], ba_t[i], ex));
      wr(OFS_CMD, {9'h0, op_t[i], 1'b0, ba_t[i], 2'b0, ad});
      poll(ST_PEND, 1'b0, 50);
      check(st[ST_REFUSED] === !ok_v[i], "refusal flag");
      wr(OFS_STATUS, 32'h8);
    end
    boot(1'b1);
    rd(OFS_STATUS, {2'b10, 20'h0, 4'h7, 8'h01}, st);
    repeat (30) @(posedge core_clk);
    check(cq.size() == 0, "commands not issued");
    check(viol_cnt === 0, "device saw bad command order");
    close_out();
  end
endmodule : testbench
